// [core/wlr_defines.svh]
`ifndef WLR_DEFINES_SVH
`define WLR_DEFINES_SVH
// ============================================================

// ============================================================
// Register byte offsets
`define WLR_ADDR_CTRL 8'h00
`define WLR_ADDR_WIDTH 8'h04
`define WLR_ADDR_PATTERN 8'h08
`define WLR_ADDR_REPEAT 8'h0c
`define WLR_ADDR_STATUS 8'h10
`define WLR_ADDR_CAPS 8'h14
`define WLR_ADDR_AAMIN 8'h18

// ============================================================
// Control field positions
`define WLR_CTRL_AA 0
`define WLR_CTRL_STIP 1
`define WLR_CTRL_MS 2
`define WLR_CTRL_SBC_LO 4
`define WLR_CTRL_SBC_HI 5

// ============================================================
// Reset values and limits (width in 1/16 pixel)
`define WLR_WIDTH_RST 12'h010
`define WLR_PATTERN_RST 16'hffff
`define WLR_REPEAT_RST 16'h0001
`define WLR_REPEAT_MAX 16'h0100
`define WLR_ALIASED_MAX 8'h0f
`define WLR_AA_MIN 12'h010
`define WLR_AA_MAX 12'h0f0
`define WLR_AA_STEP 12'h001
`define WLR_COORD_LIMIT 4096
`define WLR_SUB 8
`endif

// [core/wlr_pkg.sv]
package wlr_pkg;

    // ========================================================
    // Enumerations
    typedef enum logic [1:0] {
        WLR_ST_IDLE = 2'b00,
        WLR_ST_SETUP = 2'b01,
        WLR_ST_RUN = 2'b10
    } wlr_fsm_t;

    typedef enum logic [1:0] {
        WLR_MODE_ALIASED = 2'b00,
        WLR_MODE_AA = 2'b01,
        WLR_MODE_MS = 2'b10
    } wlr_mode_t;

    // ========================================================
    // Stream carriers
    typedef struct packed {
        logic restart;
        logic [11:0] xa;
        logic [11:0] ya;
        logic [11:0] xb;
        logic [11:0] yb;
        logic [15:0] za;
        logic [15:0] zb;
    } wlr_seg_t;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [4:0] cov;
        logic [3:0] smask;
        logic [15:0] t;
        logic [3:0][15:0] z;
    } wlr_frag_t;

    // ========================================================
    // Whole block state
    typedef struct packed {
        logic [11:0] width;
        logic [15:0] pattern;
        logic [15:0] repeat_raw;
        logic aa_en;
        logic stip_en;
        logic ms_en;
        logic [1:0] sbc;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic seg_ready;
        wlr_seg_t seg;
        wlr_fsm_t fsm;
        wlr_mode_t mode;
        logic xmaj;
        logic maj_neg;
        logic min_neg;
        logic [12:0] dmaj;
        logic [12:0] dmin;
        logic [25:0] len2;
        logic [11:0] wa;
        logic [7:0] h;
        logic [7:0] margin;
        logic signed [14:0] j;
        logic signed [14:0] jend;
        logic [7:0] k;
        logic signed [14:0] base;
        logic signed [14:0] err;
        logic [8:0] rep_eff;
        logic [3:0] bidx;
        logic [8:0] rcnt;
        logic [15:0] scount;
        logic fo_valid;
        wlr_frag_t fo;
    } wlr_state_t;

endpackage : wlr_pkg

// [core/wlr_top.sv]
`timescale 1ns/10ps
`include "wlr_defines.svh"

module wlr_top
    import wlr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic seg_valid,
    input wire wlr_seg_t seg_in,
    output logic seg_ready,
    output logic frag_valid,
    output wlr_frag_t frag_out,
    input wire logic frag_ready
);

    // ========================================================
    // Helper functions

    // Sample test against the line rectangle, in 1/8 pixel units
    function automatic logic wlr_inside(input int rx, input int ry,
            input int ox, input int oy, input int dx, input int dy,
            input longint len2, input longint wa);
        longint sx;
        longint sy;
        longint dt;
        longint cr;
        begin
            sx = longint'(rx) * `WLR_SUB + longint'(ox);
            sy = longint'(ry) * `WLR_SUB + longint'(oy);
            dt = sx * longint'(dx) + sy * longint'(dy);
            cr = sx * longint'(dy) - sy * longint'(dx);
            // Long sides at half width, short sides through ends
            wlr_inside = (len2 != 0) && (dt >= 0) &&
                (dt <= `WLR_SUB * len2) &&
                (16 * cr * cr <= wa * wa * len2);
        end
    endfunction : wlr_inside

    // Projection parameter t and linear depth at one point
    function automatic logic [31:0] wlr_tz(input int rx, input int ry,
            input int ox, input int oy, input int dx, input int dy,
            input longint len2, input int za, input int zb);
        longint dt;
        longint den;
        longint tt;
        longint zz;
        begin
            den = (len2 == 0) ? 64'sd1 : `WLR_SUB * len2;
            dt = (longint'(rx) * `WLR_SUB + longint'(ox)) * longint'(dx)
                + (longint'(ry) * `WLR_SUB + longint'(oy)) * longint'(dy);
            if (dt < 0) begin
                dt = 0;
            end else if (dt > den) begin
                dt = den;
            end
            tt = (dt * 65536) / den;
            if (tt > 65535) begin
                tt = 65535;
            end
            zz = longint'(za) + (longint'(zb - za) * dt) / den;
            wlr_tz = {tt[15:0], zz[15:0]};
        end
    endfunction : wlr_tz

    // Sample positions of the rotated four-sample grid
    function automatic int wlr_ms_ox(input int i);
        begin
            case (i)
                0: wlr_ms_ox = -1;
                1: wlr_ms_ox = 3;
                2: wlr_ms_ox = -3;
                default: wlr_ms_ox = 1;
            endcase
        end
    endfunction : wlr_ms_ox

    function automatic int wlr_ms_oy(input int i);
        begin
            case (i)
                0: wlr_ms_oy = -3;
                1: wlr_ms_oy = -1;
                2: wlr_ms_oy = 1;
                default: wlr_ms_oy = 3;
            endcase
        end
    endfunction : wlr_ms_oy

    function automatic logic [4:0] wlr_count(input logic [15:0] v);
        logic [4:0] c;
        begin
            c = 5'h00;
            for (int i = 0; i < 16; i++) begin
                c = c + {4'h0, v[i]};
            end
            wlr_count = c;
        end
    endfunction : wlr_count

    // Register read mux, unmapped offsets read as zero
    function automatic logic [31:0] wlr_read(input wlr_state_t s,
            input logic [7:0] a);
        logic [31:0] r;
        begin
            r = 32'h0;
            if (a == `WLR_ADDR_CTRL) begin
                r[`WLR_CTRL_AA] = s.aa_en;
                r[`WLR_CTRL_STIP] = s.stip_en;
                r[`WLR_CTRL_MS] = s.ms_en;
                r[`WLR_CTRL_SBC_HI:`WLR_CTRL_SBC_LO] = s.sbc;
            end else if (a == `WLR_ADDR_WIDTH) begin
                r[11:0] = s.width;
            end else if (a == `WLR_ADDR_PATTERN) begin
                r[15:0] = s.pattern;
            end else if (a == `WLR_ADDR_REPEAT) begin
                r[15:0] = s.repeat_raw;
            end else if (a == `WLR_ADDR_STATUS) begin
                r = {s.fsm != WLR_ST_IDLE, s.fo_valid, 6'h00,
                    4'h0, s.bidx, s.scount};
            end else if (a == `WLR_ADDR_CAPS) begin
                r = {`WLR_ALIASED_MAX, `WLR_AA_MAX, `WLR_AA_STEP};
            end else if (a == `WLR_ADDR_AAMIN) begin
                r[11:0] = `WLR_AA_MIN;
            end
            wlr_read = r;
        end
    endfunction : wlr_read

    // ========================================================
    // State
    wlr_state_t q;
    wlr_state_t n;

    // ========================================================
    // Candidate pixel geometry, all from registered state
    int dx_i;
    int dy_i;
    int maj_i;
    int min_i;
    int px_i;
    int py_i;
    int rx_i;
    int ry_i;
    logic in_range;
    logic [15:0] aa_hit;
    logic [3:0] ms_hit;
    logic [3:0][15:0] z_smp;
    logic [31:0] tz_ctr;

    assign dx_i = int'(q.seg.xb) - int'(q.seg.xa);
    assign dy_i = int'(q.seg.yb) - int'(q.seg.ya);
    // Walk from the start endpoint toward the end endpoint
    assign maj_i = (q.xmaj ? int'(q.seg.xa) : int'(q.seg.ya))
        + (q.maj_neg ? -int'(q.j) : int'(q.j));
    // Lowest fragment of a column sits on the shifted line
    assign min_i = int'(q.base) + int'(q.k) - int'(q.margin);
    assign px_i = q.xmaj ? maj_i : min_i;
    assign py_i = q.xmaj ? min_i : maj_i;
    assign rx_i = px_i - int'(q.seg.xa);
    assign ry_i = py_i - int'(q.seg.ya);
    // Pixels off the window are skipped, not wrapped
    assign in_range = (px_i >= 0) && (px_i < `WLR_COORD_LIMIT) &&
        (py_i >= 0) && (py_i < `WLR_COORD_LIMIT);

    // Coverage estimate from a 4x4 grid of sub-pixel points
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_aa
            assign aa_hit[gi] = wlr_inside(rx_i, ry_i,
                2 * (gi % 4) - 3, 2 * (gi / 4) - 3, dx_i, dy_i,
                longint'(q.len2), longint'(q.wa));
        end
        for (gi = 0; gi < 4; gi++) begin : g_ms
            logic [31:0] tz_s;
            assign ms_hit[gi] = wlr_inside(rx_i, ry_i, wlr_ms_ox(gi),
                wlr_ms_oy(gi), dx_i, dy_i, longint'(q.len2),
                longint'(q.wa));
            assign tz_s = wlr_tz(rx_i, ry_i, wlr_ms_ox(gi),
                wlr_ms_oy(gi), dx_i, dy_i, longint'(q.len2),
                int'(q.seg.za), int'(q.seg.zb));
            assign z_smp[gi] = tz_s[15:0];
        end
    endgenerate

    // Associated data and single depth at the pixel centre
    assign tz_ctr = wlr_tz(rx_i, ry_i, 0, 0, dx_i, dy_i,
        longint'(q.len2), int'(q.seg.za), int'(q.seg.zb));

    // ========================================================
    // Next state: bus slave, then segment walker
    always_comb begin
        int adx;
        int ady;
        int wr;
        int wa;
        int hwi;
        int mi;
        int rep;
        logic keep;
        logic emit;
        logic in_seg;
        logic progress;
        adx = 0;
        ady = 0;
        wr = 0;
        wa = 0;
        hwi = 0;
        mi = 0;
        rep = 0;
        keep = 1'b0;
        emit = 1'b0;
        in_seg = 1'b0;
        progress = !q.fo_valid || frag_ready;
        n = q;

        // Data phase of a write from the previous address phase
        if (q.wr_pend) begin
            n.wr_pend = 1'b0;
            if (q.wr_addr == `WLR_ADDR_CTRL) begin
                n.aa_en = hwdata[`WLR_CTRL_AA];
                n.stip_en = hwdata[`WLR_CTRL_STIP];
                n.ms_en = hwdata[`WLR_CTRL_MS];
                n.sbc = hwdata[`WLR_CTRL_SBC_HI:`WLR_CTRL_SBC_LO];
            end else if (q.wr_addr == `WLR_ADDR_WIDTH) begin
                n.width = hwdata[11:0];
            end else if (q.wr_addr == `WLR_ADDR_PATTERN) begin
                n.pattern = hwdata[15:0];
            end else if (q.wr_addr == `WLR_ADDR_REPEAT) begin
                n.repeat_raw = hwdata[15:0];
            end
        end
        // Address phase; read data forwards a write just landed
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                n.wr_pend = 1'b1;
                n.wr_addr = haddr[7:0];
            end else begin
                n.hrdata = wlr_read(n, haddr[7:0]);
            end
        end

        // Output register drains when downstream takes it
        if (progress) begin
            n.fo_valid = 1'b0;
        end

        case (q.fsm)
            WLR_ST_IDLE: begin
                if (seg_valid && q.seg_ready) begin
                    n.seg = seg_in;
                    n.seg_ready = 1'b0;
                    n.fsm = WLR_ST_SETUP;
                end
            end
            WLR_ST_SETUP: begin
                adx = (dx_i < 0) ? -dx_i : dx_i;
                ady = (dy_i < 0) ? -dy_i : dy_i;
                n.xmaj = adx >= ady;
                n.dmaj = 13'(n.xmaj ? adx : ady);
                n.dmin = 13'(n.xmaj ? ady : adx);
                n.maj_neg = n.xmaj ? (dx_i < 0) : (dy_i < 0);
                n.min_neg = n.xmaj ? (dy_i < 0) : (dx_i < 0);
                n.len2 = 26'(adx * adx + ady * ady);
                mi = n.xmaj ? int'(q.seg.ya) : int'(q.seg.xa);
                // Round to nearest, zero counts as one, then clamp
                wr = (int'(q.width) + 8) / 16;
                if (wr == 0) begin
                    wr = 1;
                end
                if (wr > int'(`WLR_ALIASED_MAX)) begin
                    wr = int'(`WLR_ALIASED_MAX);
                end
                // AA width held inside the reported range
                wa = int'(q.width);
                if (wa < int'(`WLR_AA_MIN)) begin
                    wa = int'(`WLR_AA_MIN);
                end else if (wa > int'(`WLR_AA_MAX)) begin
                    wa = int'(`WLR_AA_MAX);
                end
                n.wa = 12'(wa);
                hwi = (wa + 31) / 32;
                // Multisample wins over the antialias enable
                if (q.ms_en && q.sbc == 2'b01) begin
                    n.mode = WLR_MODE_MS;
                end else if (q.aa_en) begin
                    n.mode = WLR_MODE_AA;
                end else begin
                    n.mode = WLR_MODE_ALIASED;
                end
                if (n.mode == WLR_MODE_ALIASED) begin
                    n.h = 8'(wr);
                    n.margin = 8'h00;
                    n.base = 15'(mi - (wr - 1) / 2);
                    n.j = 15'sd0;
                    n.jend = 15'(adx > ady ? adx - 1 : ady - 1);
                end else begin
                    // Scan the rectangle's box plus one pixel
                    n.h = 8'(2 * hwi + 3);
                    n.margin = 8'(hwi + 1);
                    n.base = 15'(mi);
                    n.j = 15'(-(hwi + 1));
                    n.jend = 15'(int'(n.dmaj) + hwi + 1);
                end
                n.err = 15'(2 * int'(n.dmin) - int'(n.dmaj));
                n.k = 8'h00;
                rep = int'(q.repeat_raw);
                if (rep < 1) begin
                    rep = 1;
                end else if (rep > int'(`WLR_REPEAT_MAX)) begin
                    rep = int'(`WLR_REPEAT_MAX);
                end
                n.rep_eff = 9'(rep);
                if (q.seg.restart) begin
                    n.bidx = 4'h0;
                    n.rcnt = 9'h000;
                    n.scount = 16'h0000;
                end
                // Degenerate segments produce nothing
                if (n.dmaj == 13'h0000) begin
                    n.fsm = WLR_ST_IDLE;
                    n.seg_ready = 1'b1;
                end else begin
                    n.fsm = WLR_ST_RUN;
                end
            end
            WLR_ST_RUN: begin
                if (progress) begin
                    // One stipple bit masks a whole column or piece
                    keep = !q.stip_en || q.pattern[q.bidx];
                    n.fo.x = px_i[11:0];
                    n.fo.y = py_i[11:0];
                    n.fo.t = tz_ctr[31:16];
                    if (q.mode == WLR_MODE_ALIASED) begin
                        emit = in_range && keep;
                        n.fo.cov = 5'h10;
                        n.fo.smask = 4'hf;
                        n.fo.z = {4{tz_ctr[15:0]}};
                    end else if (q.mode == WLR_MODE_AA) begin
                        // Pieces skip cull, fill style, area stipple
                        emit = in_range && keep && (|aa_hit);
                        n.fo.cov = wlr_count(aa_hit);
                        n.fo.smask = 4'hf;
                        n.fo.z = {4{tz_ctr[15:0]}};
                    end else begin
                        emit = in_range && keep && (|ms_hit);
                        n.fo.cov = 5'(wlr_count({12'h000, ms_hit}) * 4);
                        n.fo.smask = ms_hit;
                        n.fo.z = z_smp;
                    end
                    n.fo_valid = emit;
                    if (q.k == q.h - 8'h01) begin
                        n.k = 8'h00;
                        in_seg = (q.j >= 0) &&
                            (int'(q.j) < int'(q.dmaj));
                        if (in_seg) begin
                            // Step the minor axis, Bresenham style
                            if (q.err > 0) begin
                                n.base = q.min_neg ? q.base - 15'sd1
                                    : q.base + 15'sd1;
                                n.err = 15'(int'(q.err) + 2 *
                                    int'(q.dmin) - 2 * int'(q.dmaj));
                            end else begin
                                n.err = 15'(int'(q.err) +
                                    2 * int'(q.dmin));
                            end
                            // Counter divided by repeat, modulo 16
                            n.scount = q.scount + 16'h0001;
                            if (q.rcnt + 9'h001 == q.rep_eff) begin
                                n.rcnt = 9'h000;
                                n.bidx = q.bidx + 4'h1;
                            end else begin
                                n.rcnt = q.rcnt + 9'h001;
                            end
                        end
                        if (q.j == q.jend) begin
                            n.fsm = WLR_ST_IDLE;
                            n.seg_ready = 1'b1;
                        end else begin
                            n.j = q.j + 15'sd1;
                        end
                    end else begin
                        n.k = q.k + 8'h01;
                    end
                end
            end
            default: begin
                n.fsm = WLR_ST_IDLE;
                n.seg_ready = 1'b1;
            end
        endcase
    end

    // ========================================================
    // State register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.width <= `WLR_WIDTH_RST;
            q.pattern <= `WLR_PATTERN_RST;
            q.repeat_raw <= `WLR_REPEAT_RST;
            q.rep_eff <= 9'h001;
            q.hready <= 1'b1;
            q.seg_ready <= 1'b1;
            q.fsm <= WLR_ST_IDLE;
        end else begin
            q <= n;
        end
    end

    // ========================================================
    // Outputs straight from the state register
    assign hrdata = q.hrdata;
    assign hreadyout = q.hready;
    assign hresp = q.hresp;
    assign seg_ready = q.seg_ready;
    assign frag_valid = q.fo_valid;
    assign frag_out = q.fo;

endmodule : wlr_top

// [verification/wlr_properties.sv]
`timescale 1ns/10ps
// ====================================================
// Port checker for the line rasterizer
module wlr_props
    import wlr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic seg_valid,
    input wire logic seg_ready,
    input wire logic frag_valid,
    input wire wlr_frag_t frag_out,
    input wire logic frag_ready
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Outputs leave reset idle and empty
    chk_rst_state: assert property ($past(!rst_n) |-> seg_ready && !frag_valid)
        else $error("outputs not idle after reset");
    // Stalled fragment must not move
    chk_frag_hold: assert property (frag_valid && !frag_ready |=> frag_valid && $stable(frag_out))
        else $error("fragment changed under stall");
    // Setup cycle keeps input closed; zero-length ends right after it
    chk_seg_take: assert property (seg_valid && seg_ready |=> !seg_ready)
        else $error("segment input reopened early");
    chk_seg_drop: assert property ($fell(seg_ready) |-> $past(seg_valid))
        else $error("input closed without an offer");
    chk_frag_busy: assert property ($rose(frag_valid) |-> $past(!seg_ready))
        else $error("fragment launched while idle");
    // Coverage is sixteenths, never above full
    chk_cov_range: assert property (frag_valid |-> frag_out.cov <= 5'h10)
        else $error("coverage above one");
    chk_smask_cov: assert property (frag_valid && frag_out.smask != 4'h0 |-> frag_out.cov != 5'h0)
        else $error("sample bits with zero coverage");
endmodule : wlr_props

bind wlr_top wlr_props chk_u (.clk_sys, .rst_n, .seg_valid, .seg_ready,
    .frag_valid, .frag_out, .frag_ready);

// [verification/wlr_sink.sv]
`timescale 1ns/10ps
// ====================================================
// Downstream fragment consumer
module wlr_sink (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic stall_en,
    output logic frag_ready
);
    // Random stalls shake out hold bugs on the output
    always @(posedge clk_sys) begin
        if (!rst_n)
            frag_ready <= 1'b0;
        else
            frag_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
    end
endmodule : wlr_sink

// [verification/wlr_top_tb.sv]
`timescale 1ns/10ps
// ====================================================
// Self-checking bench
module wlr_top_tb
    import wlr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, seg_ready, frag_valid, frag_ready;
    logic seg_valid = 1'b0;
    logic free_run = 1'b0;
    wlr_seg_t seg_in = '0;
    wlr_frag_t frag_out;
    logic [23:0] exp_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int free_cnt = 0;
    logic [11:0] wt[3] = '{12'h007, 12'h030, 12'h200};
    int we[3] = '{1, 3, 15};
    logic [31:0] rp[3] = '{32'h0, 32'h2, 32'h300};
    logic [31:0] cm[4] = '{32'h1, 32'h3, 32'h14, 32'h16};

    wlr_top dut_u (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .seg_valid, .seg_in, .seg_ready, .frag_valid, .frag_out,
        .frag_ready);
    wlr_sink sink_u (.clk_sys, .rst_n, .stall_en(1'b1), .frag_ready);

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // One single AHB word; reads compare against d
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (!hreadyout && n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (wr)
            hwdata <= d;
        do begin @(posedge clk_sys); n++; end while (!hreadyout && n < 100);
        if (n >= 100) begin error_cnt++; tally_and_finish(); end
        if (!wr)
            check(hrdata, d);
    endtask : bus

    // Expected column of w fragments along the minor axis
    task automatic col(input int m, input int b, input int w, input bit ymaj);
        for (int i = 0; i < w; i++)
            exp_q.push_back(ymaj ? {12'(b + i), 12'(m)} : {12'(m), 12'(b + i)});
    endtask : col

    task automatic draw(input int xa, input int ya, input int xb, input int yb);
        int n;
        seg_in <= '{1'b1, 12'(xa), 12'(ya), 12'(xb), 12'(yb), 16'h0, 16'hffff};
        seg_valid <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (!seg_ready && n < 50);
        seg_valid <= 1'b0;
        do begin @(posedge clk_sys); n++; end
            while (!(seg_ready && !frag_valid && exp_q.size() == 0) && n < 2000);
        if (n >= 2000) begin error_cnt++; tally_and_finish(); end
    endtask : draw

    // Oldest expectation against each accepted fragment
    always @(posedge clk_sys) begin
        // Smooth modes are only counted, coverage and masks left to the checker
        if (rst_n && frag_valid === 1'b1 && frag_ready === 1'b1 && free_run)
            free_cnt++;
        if (rst_n && frag_valid === 1'b1 && frag_ready && !free_run) begin
            if (exp_q.size() == 0)
                check(32'hdead, 32'h0);
            else
                check({8'h0, frag_out.x, frag_out.y}, {8'h0, exp_q.pop_front()});
        end
    end

    // ================================================
    // Main sequence
    initial begin
        int xa, ya, n, r;
        void'($urandom(98958));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, 8'h00, 32'h0);
        bus(1'b0, 8'h04, 32'h10);
        bus(1'b0, 8'h08, 32'hffff);
        bus(1'b0, 8'h0c, 32'h1);
        bus(1'b0, 8'h14, 32'h0f0f0001);
        bus(1'b0, 8'h18, 32'h10);
        bus(1'b1, 8'h1c, 32'hffffffff);
        bus(1'b0, 8'h1c, 32'h0);
        $display("test registers done");
        // Single width: random spans, then a slope of one
        for (int i = 0; i < 4; i++) begin
            xa = $urandom_range(4000);
            ya = $urandom_range(4000);
            n = $urandom_range(6, 1);
            for (int k = 0; k < n; k++) col(xa + k, ya, 1, 0);
            draw(xa, ya, xa + n, ya);
        end
        for (int k = 0; k < 3; k++) col(k, k, 1, 0);
        draw(0, 0, 3, 3);
        $display("test single width done");
        // Round to zero, odd width, clamp to maximum
        foreach (wt[i]) begin
            bus(1'b1, 8'h04, {20'h0, wt[i]});
            for (int c = 0; c < 2; c++) col(100 + c, 100 - (we[i] - 1) / 2, we[i], 0);
            draw(100, 100, 102, 100);
        end
        bus(1'b1, 8'h04, 32'h30);
        for (int c = 0; c < 3; c++) col(5 + c, 4, 3, 1);
        draw(5, 5, 5, 8);
        $display("test wide done");
        // Stipple at width two, a repeat of two and repeat counts needing clamps
        bus(1'b1, 8'h04, 32'h20);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b1, 8'h08, 32'h5);
        foreach (rp[i]) begin
            bus(1'b1, 8'h0c, rp[i]);
            r = rp[i] == 0 ? 1 : rp[i] > 256 ? 256 : int'(rp[i]);
            for (int s = 0; s < 6; s++)
                if (((16'h5 >> ((s / r) % 16)) & 1) != 0) col(s, 50, 2, 0);
            draw(0, 50, 6, 50);
        end
        $display("test stipple done");
        // Smooth and multisample modes run under the checker
        free_run <= 1'b1;
        foreach (cm[i]) begin
            bus(1'b1, 8'h00, cm[i]);
            draw(10, 10, 14, 12);
        end
        free_run <= 1'b0;
        check(32'(free_cnt != 0), 32'h1);
        // Two sample_buffer_count fall back to aliased drawing
        bus(1'b1, 8'h00, 32'h24);
        for (int c = 0; c < 3; c++) col(20 + c, 30, 2, 0);
        draw(20, 30, 23, 30);
        $display("test modes done");
        tally_and_finish();
    end
endmodule : wlr_top_tb
